// ---- inc/adcrg_pkg.sv ----
package adcrg_pkg;
    // ==========================================================
    // widths and counts
    localparam int unsigned DATA_W = 10;
    localparam int unsigned RES_W = 11;
    localparam int unsigned NUM_CH = 8;
    localparam int unsigned NUM_RES = 4;
    localparam int unsigned NUM_SRC = 2;
    localparam int unsigned NUM_LINES = 2;
    localparam int unsigned NUM_TRIG = 8;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_MISC = 8'h00;
    localparam logic [7:0] OFS_GLOB = 8'h04;
    localparam logic [7:0] OFS_BOUND = 8'h08;
    localparam logic [7:0] OFS_CHPTR = 8'h0c;
    localparam logic [7:0] OFS_EVPTR = 8'h10;
    localparam logic [7:0] OFS_RESCTL = 8'h14;
    localparam logic [7:0] OFS_TRIG = 8'h18;
    localparam logic [7:0] OFS_VALID = 8'h1c;
    localparam logic [2:0] OFS_CHCTL_HI = 3'h1;
    localparam logic [3:0] OFS_NORM_HI = 4'h4;
    localparam logic [3:0] OFS_ACCU_HI = 4'h5;

    // ==========================================================
    // field positions
    localparam int unsigned MISC_STORE_BIT = 0;
    localparam int unsigned MISC_TRIG1_BIT = 6;
    localparam int unsigned MISC_TRIG0_BIT = 7;
    localparam int unsigned GLOB_WIDTH_BIT = 6;
    localparam int unsigned BOUND_A_LSB = 0;
    localparam int unsigned BOUND_B_LSB = 16;
    localparam int unsigned RESCTL_FILT_LSB = 0;
    localparam int unsigned RESCTL_EV_LSB = 4;
    localparam int unsigned RESCTL_SRC_LSB = 8;
    localparam int unsigned TRIG_FIELD_W = 4;
    localparam int unsigned TRIG_BYP_OFS = 3;
    localparam int unsigned CHCTL_LCC_LSB = 0;
    localparam int unsigned CHCTL_SEL_LSB = 4;
    localparam int unsigned EV_SEQ = 0;
    localparam int unsigned EV_PAR = 1;
    localparam int unsigned EV_RES0 = 4;

    // ==========================================================
    // reset values
    localparam logic [7:0] MISC_RST = 8'h00;
    localparam logic WIDTH_RST = 1'b0;
    localparam logic [DATA_W-1:0] BOUND_RST = 10'h000;
    localparam logic [2:0] LCC_RST = 3'h0;

    // ==========================================================
    // limit condition codes
    localparam logic [2:0] LCC_NONE = 3'h0;
    localparam logic [2:0] LCC_NOT_A1 = 3'h1;
    localparam logic [2:0] LCC_NOT_A2 = 3'h2;
    localparam logic [2:0] LCC_NOT_A3 = 3'h3;
    localparam logic [2:0] LCC_ALWAYS = 3'h4;
    localparam logic [2:0] LCC_IN_A1 = 3'h5;
    localparam logic [2:0] LCC_IN_A2 = 3'h6;
    localparam logic [2:0] LCC_IN_A3 = 3'h7;
endpackage

// ---- core/adcrg_top.sv ----
// How it works
// RULE_01 - compare result with boundary a, then boundary b, on valid store
// RULE_02 - below both is area one, above both area three, else two
// RULE_03 - condition code picks none, not-area, always or in-area trigger
// RULE_04 - met condition after conversion raises its channel interrupt, one at once
// RULE_05 - each of eight channels has a pointer choosing its service line
// RULE_06 - counter zero: reload from filter bit, add zero, store sum
// RULE_07 - filter off: every store makes result event and valid flag
// RULE_08 - filter on: first of pair makes no event and no valid
// RULE_09 - counter one: add to stored value, decrement, store, event, valid
// RULE_10 - result path takes same cycles with filter on or off
// RULE_11 - at most two results summed into eleven-bit registers
// RULE_12 - four result registers, each channel selects its target register
// RULE_13 - accumulated view gives full width, normal view the usual width
// RULE_14 - normal view of accumulated sum drops its top bit
// RULE_15 - two service lines, each an OR of routed pulses
// RULE_16 - source events and result events gated, each with line pointer
// RULE_17 - events 0,1 are sources, 4 to 7 result registers
// RULE_18 - each source picks one of eight trigger inputs by select
// RULE_19 - per-source bit bypasses trigger synchroniser stages
// RULE_20 - timer units drive trigger inputs two to seven
// RULE_21 - control bit 6 picks trigger one: timer a or b channel 5
// RULE_22 - control bit 7 picks trigger zero source
// RULE_23 - bit 7 zero is period match, one overflow, zero after reset
// RULE_24 - every interrupt and event is a one-cycle pulse
// RULE_25 - width bit zero gives ten-bit results, one gives eight-bit
module adcrg_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic convDone,
    input wire logic [2:0] convChannel,
    input wire logic convSource,
    input wire logic [9:0] convData,
    input wire logic periodMatchA,
    input wire logic overflowB,
    input wire logic compareMatchA,
    input wire logic compareMatchB5,
    input wire logic [5:0] timerTrig,
    output logic [1:0] sourceTrigger,
    output logic [1:0] serviceRequest,
    output logic resultWidthSelect,
    output logic dataStoreEnable
);
    // ==========================================================
    // state
    logic waitReq_r;
    logic [31:0] readData_r;
    logic [7:0] misc_r;
    logic widthSel_r;
    logic [9:0] boundA_r;
    logic [9:0] boundB_r;
    logic [7:0] chanPtr_r;
    logic [7:0] evPtr_r;
    logic [3:0] filterEn_r;
    logic [3:0] resEvEn_r;
    logic [1:0] srcEvEn_r;
    logic [7:0] trigCtl_r;
    logic [3:0] validFlag_r;
    logic [3:0] redCnt_r;
    logic [1:0] srq_r;
    logic [1:0] srcTrig_r;
    logic [2:0] lcc_r [8];
    logic [1:0] resSel_r [8];
    logic [10:0] result_r [4];

    // ==========================================================
    // bus decode: one wait cycle, write lands when waitrequest low
    wire busReq = avs_read || avs_write;
    wire wrAcc = avs_write && !waitReq_r;
    wire rdTake = avs_read && waitReq_r;
    wire wrMisc = wrAcc && (avs_address == adcrg_pkg::OFS_MISC);
    wire wrGlob = wrAcc && (avs_address == adcrg_pkg::OFS_GLOB);
    wire wrBound = wrAcc && (avs_address == adcrg_pkg::OFS_BOUND);
    wire wrChPtr = wrAcc && (avs_address == adcrg_pkg::OFS_CHPTR);
    wire wrEvPtr = wrAcc && (avs_address == adcrg_pkg::OFS_EVPTR);
    wire wrResCtl = wrAcc && (avs_address == adcrg_pkg::OFS_RESCTL);
    wire wrTrig = wrAcc && (avs_address == adcrg_pkg::OFS_TRIG);
    wire wrValid = wrAcc && (avs_address == adcrg_pkg::OFS_VALID);
    wire isChCtl = (avs_address[7:5] == adcrg_pkg::OFS_CHCTL_HI) && (avs_address[1:0] == 2'h0);
    wire isNorm = (avs_address[7:4] == adcrg_pkg::OFS_NORM_HI) && (avs_address[1:0] == 2'h0);
    wire isAccu = (avs_address[7:4] == adcrg_pkg::OFS_ACCU_HI) && (avs_address[1:0] == 2'h0);
    wire [2:0] chIdx = avs_address[4:2];
    wire [1:0] rIdx = avs_address[3:2];

    // ==========================================================
    // result path, one edge from convDone to store in both modes
    // RULE_12 target register select
    wire [1:0] tgt = resSel_r[convChannel];
    // RULE_25 width of incoming value
    wire [9:0] inData = widthSel_r ? {2'h0, convData[7:0]} : convData;
    wire accum = redCnt_r[tgt];
    // RULE_06 add zero when counter is zero
    wire [10:0] base = accum ? result_r[tgt] : 11'h000;
    // RULE_11 two values of ten bits fit eleven
    wire [10:0] sum = base + {1'b0, inData};
    // RULE_07 valid store when filter off or pair complete
    wire storeValid = convDone && (accum || !filterEn_r[tgt]);

    // ==========================================================
    // limit check against both boundaries
    // RULE_01 boundary a first, then b
    wire lowA = sum < {1'b0, boundA_r};
    wire lowB = sum < {1'b0, boundB_r};
    wire highA = sum > {1'b0, boundA_r};
    wire highB = sum > {1'b0, boundB_r};
    // RULE_02 area classification
    wire area1 = lowA && lowB;
    wire area3 = highA && highB;
    wire area2 = !area1 && !area3;
    logic limitHit;

    // RULE_03 condition decode
    always_comb begin
        case (lcc_r[convChannel])
            adcrg_pkg::LCC_NONE: limitHit = 1'b0;
            adcrg_pkg::LCC_NOT_A1: limitHit = !area1;
            adcrg_pkg::LCC_NOT_A2: limitHit = !area2;
            adcrg_pkg::LCC_NOT_A3: limitHit = !area3;
            adcrg_pkg::LCC_ALWAYS: limitHit = 1'b1;
            adcrg_pkg::LCC_IN_A1: limitHit = area1;
            adcrg_pkg::LCC_IN_A2: limitHit = area2;
            adcrg_pkg::LCC_IN_A3: limitHit = area3;
            default: limitHit = 1'b0;
        endcase
    end

    // ==========================================================
    // event and interrupt pulses, one cycle each
    // RULE_04 channel interrupt on met condition
    wire chanIrq = storeValid && limitHit;
    wire [7:0] evPulse;
    logic [1:0] srqNxt;
    // RULE_16 RULE_17 source events 0 and 1
    assign evPulse[adcrg_pkg::EV_SEQ] = convDone && !convSource && srcEvEn_r[0];
    assign evPulse[adcrg_pkg::EV_PAR] = convDone && convSource && srcEvEn_r[1];
    assign evPulse[3:2] = 2'h0;

    genvar gr;
    generate
        for (gr = 0; gr < 4; gr++) begin : g_res
            // RULE_16 RULE_17 result events 4 to 7
            assign evPulse[adcrg_pkg::EV_RES0 + gr] = storeValid && (tgt == 2'(gr)) && resEvEn_r[gr];

            // result store, counter and valid flag for this register
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    result_r[gr] <= 11'h000;
                    redCnt_r[gr] <= 1'b0;
                    validFlag_r[gr] <= 1'b0;
                end else begin
                    // RULE_06 RULE_09 RULE_10 reload or decrement, same edge in either mode
                    if (convDone && tgt == 2'(gr)) begin
                        result_r[gr] <= sum;
                        redCnt_r[gr] <= accum ? 1'b0 : filterEn_r[gr];
                    end
                    // RULE_07 RULE_08 set wins over clear
                    if (storeValid && tgt == 2'(gr))
                        validFlag_r[gr] <= 1'b1;
                    else if (wrValid && avs_writedata[gr])
                        validFlag_r[gr] <= 1'b0;
                end
            end
        end
    endgenerate

    // RULE_15 RULE_05 OR of routed pulses per line
    always_comb begin
        srqNxt = 2'h0;
        for (int e = 0; e < 8; e++) begin
            if (evPulse[e])
                srqNxt[evPtr_r[e]] = 1'b1;
        end
        if (chanIrq)
            srqNxt[chanPtr_r[convChannel]] = 1'b1;
    end

    // ==========================================================
    // per-channel control
    genvar gc;
    generate
        for (gc = 0; gc < 8; gc++) begin : g_ch
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    lcc_r[gc] <= adcrg_pkg::LCC_RST;
                    resSel_r[gc] <= 2'h0;
                end else if (wrAcc && isChCtl && chIdx == 3'(gc)) begin
                    lcc_r[gc] <= avs_writedata[adcrg_pkg::CHCTL_LCC_LSB +: 3];
                    resSel_r[gc] <= avs_writedata[adcrg_pkg::CHCTL_SEL_LSB +: 2];
                end
            end
        end
    endgenerate

    // ==========================================================
    // external triggers
    wire [7:0] trigVec;
    // RULE_22 RULE_23 trigger zero source
    assign trigVec[0] = misc_r[adcrg_pkg::MISC_TRIG0_BIT] ? overflowB : periodMatchA;
    // RULE_21 trigger one source
    assign trigVec[1] = misc_r[adcrg_pkg::MISC_TRIG1_BIT] ? compareMatchB5 : compareMatchA;
    // RULE_20 timer events on two to seven
    assign trigVec[7:2] = timerTrig;
    wire [1:0] trigSelBit;

    genvar gs;
    generate
        for (gs = 0; gs < 2; gs++) begin : g_src
            logic syncA_r;
            logic syncB_r;
            // RULE_18 eight-way trigger select
            assign trigSelBit[gs] = trigVec[trigCtl_r[gs * adcrg_pkg::TRIG_FIELD_W +: 3]];

            // two-stage synchroniser, first stage feeds only the second
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    syncA_r <= 1'b0;
                    syncB_r <= 1'b0;
                    srcTrig_r[gs] <= 1'b0;
                end else begin
                    syncA_r <= trigSelBit[gs];
                    syncB_r <= syncA_r;
                    // RULE_19 bypass for already-synchronous triggers
                    srcTrig_r[gs] <= trigCtl_r[gs * adcrg_pkg::TRIG_FIELD_W + adcrg_pkg::TRIG_BYP_OFS]
                        ? trigSelBit[gs] : syncB_r;
                end
            end
        end
    endgenerate

    // ==========================================================
    // read mux, unmapped reads as zero
    logic [31:0] rdNxt;
    always_comb begin
        rdNxt = 32'h0000_0000;
        if (avs_address == adcrg_pkg::OFS_MISC)
            rdNxt = {24'h0, misc_r[7:6], 5'h00, misc_r[adcrg_pkg::MISC_STORE_BIT]};
        else if (avs_address == adcrg_pkg::OFS_GLOB)
            rdNxt = 32'(widthSel_r) << adcrg_pkg::GLOB_WIDTH_BIT;
        else if (avs_address == adcrg_pkg::OFS_BOUND)
            rdNxt = {6'h00, boundB_r, 6'h00, boundA_r};
        else if (avs_address == adcrg_pkg::OFS_CHPTR)
            rdNxt = {24'h0, chanPtr_r};
        else if (avs_address == adcrg_pkg::OFS_EVPTR)
            rdNxt = {24'h0, evPtr_r[7:4], 2'h0, evPtr_r[1:0]};
        else if (avs_address == adcrg_pkg::OFS_RESCTL)
            rdNxt = {22'h0, srcEvEn_r, resEvEn_r, filterEn_r};
        else if (avs_address == adcrg_pkg::OFS_TRIG)
            rdNxt = {24'h0, trigCtl_r};
        else if (avs_address == adcrg_pkg::OFS_VALID)
            rdNxt = {28'h0, validFlag_r};
        else if (isChCtl)
            rdNxt = {26'h0, resSel_r[chIdx], 1'b0, lcc_r[chIdx]};
        // RULE_13 RULE_14 normal view drops the sum's top bit
        else if (isNorm)
            rdNxt = widthSel_r ? {24'h0, result_r[rIdx][7:0]} : {22'h0, result_r[rIdx][9:0]};
        // RULE_13 accumulated view full width
        else if (isAccu)
            rdNxt = widthSel_r ? {23'h0, result_r[rIdx][8:0]} : {21'h0, result_r[rIdx]};
    end

    // bus handshake and read data
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            waitReq_r <= 1'b1;
            readData_r <= 32'h0000_0000;
        end else begin
            waitReq_r <= !(busReq && waitReq_r);
            if (rdTake)
                readData_r <= rdNxt;
        end
    end

    // software configuration registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            misc_r <= adcrg_pkg::MISC_RST;
            widthSel_r <= adcrg_pkg::WIDTH_RST;
            boundA_r <= adcrg_pkg::BOUND_RST;
            boundB_r <= adcrg_pkg::BOUND_RST;
            chanPtr_r <= 8'h00;
            evPtr_r <= 8'h00;
            {srcEvEn_r, resEvEn_r, filterEn_r} <= 10'h000;
            trigCtl_r <= 8'h00;
        end else begin
            if (wrMisc)
                misc_r <= avs_writedata[7:0] & 8'hc1;
            if (wrGlob)
                widthSel_r <= avs_writedata[adcrg_pkg::GLOB_WIDTH_BIT];
            if (wrBound) begin
                boundA_r <= avs_writedata[adcrg_pkg::BOUND_A_LSB +: 10];
                boundB_r <= avs_writedata[adcrg_pkg::BOUND_B_LSB +: 10];
            end
            if (wrChPtr)
                chanPtr_r <= avs_writedata[7:0];
            if (wrEvPtr)
                evPtr_r <= avs_writedata[7:0] & 8'hf3;
            if (wrResCtl)
                {srcEvEn_r, resEvEn_r, filterEn_r} <= avs_writedata[9:0];
            if (wrTrig)
                trigCtl_r <= avs_writedata[7:0];
        end
    end

    // RULE_24 pulses registered onto lines
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            srq_r <= 2'h0;
        else
            srq_r <= srqNxt;
    end

    assign avs_waitrequest = waitReq_r;
    assign avs_readdata = readData_r;
    assign serviceRequest = srq_r;
    assign sourceTrigger = srcTrig_r;
    assign resultWidthSelect = widthSel_r;
    assign dataStoreEnable = misc_r[adcrg_pkg::MISC_STORE_BIT];

    // ==========================================================
    // checks
    property p_first_store;
        @(posedge clk) disable iff (sys_rst)
        convDone && !accum |=> result_r[$past(tgt)] == {1'b0, $past(inData)};
    endproperty
    a_first_store: assert property (p_first_store) else $error("first store not plain value"); // RULE_06

    property p_filter_off_valid;
        @(posedge clk) disable iff (sys_rst)
        convDone && !filterEn_r[tgt] |=> validFlag_r[$past(tgt)];
    endproperty
    a_filter_off_valid: assert property (p_filter_off_valid) else $error("valid flag not set"); // RULE_07

    property p_first_no_event;
        @(posedge clk) disable iff (sys_rst)
        convDone && !accum && filterEn_r[tgt] |-> !storeValid ##1 redCnt_r[$past(tgt)];
    endproperty
    a_first_no_event: assert property (p_first_no_event) else $error("first of pair flagged"); // RULE_08

    property p_second_sum;
        @(posedge clk) disable iff (sys_rst)
        convDone && accum |=> result_r[$past(tgt)] == $past(result_r[tgt]) + 11'($past(inData))
            && !redCnt_r[$past(tgt)];
    endproperty
    a_second_sum: assert property (p_second_sum) else $error("pair sum wrong"); // RULE_09

    property p_always_irq;
        @(posedge clk) disable iff (sys_rst)
        storeValid && lcc_r[convChannel] == adcrg_pkg::LCC_ALWAYS |=> srq_r[$past(chanPtr_r[convChannel])];
    endproperty
    a_always_irq: assert property (p_always_irq) else $error("channel interrupt missing"); // RULE_04

    property p_area_excl;
        @(posedge clk) disable iff (sys_rst)
        convDone |-> (32'(area1) + 32'(area2) + 32'(area3)) == 1
            && area2 == ((sum >= {1'b0, boundA_r} || sum >= {1'b0, boundB_r})
            && (sum <= {1'b0, boundA_r} || sum <= {1'b0, boundB_r}));
    endproperty
    a_area_excl: assert property (p_area_excl) else $error("area not unique"); // RULE_02

    property p_srq_cause;
        @(posedge clk) disable iff (sys_rst)
        srq_r != 2'h0 |-> $past(convDone);
    endproperty
    a_srq_cause: assert property (p_srq_cause) else $error("service request without cause"); // RULE_15

    property p_bypass;
        @(posedge clk) disable iff (sys_rst)
        trigCtl_r[adcrg_pkg::TRIG_BYP_OFS] |=> srcTrig_r[0] == $past(trigSelBit[0]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass path wrong"); // RULE_19

    property p_sync_delay;
        @(posedge clk) disable iff (sys_rst)
        !trigCtl_r[adcrg_pkg::TRIG_BYP_OFS] [*4] |-> srcTrig_r[0] == $past(trigSelBit[0], 3);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync path depth wrong"); // RULE_19

    property p_trig0_src;
        @(posedge clk) disable iff (sys_rst)
        !misc_r[adcrg_pkg::MISC_TRIG0_BIT] |-> trigVec[0] == periodMatchA;
    endproperty
    a_trig0_src: assert property (p_trig0_src) else $error("trigger zero source wrong"); // RULE_23
endmodule

// ---- verif/adcrg_far_model.sv ----
// ==========================================================
// conversion arbiter and timer units seen from the result path
module adcrg_far_model (
    input wire logic clk,
    output logic convDone,
    output logic [2:0] convChannel,
    output logic convSource,
    output logic [9:0] convData,
    output logic periodMatchA,
    output logic overflowB,
    output logic compareMatchA,
    output logic compareMatchB5,
    output logic [5:0] timerTrig
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet start, all timer events low
    initial begin
        convDone = 1'b0;
        convChannel = 3'h0;
        convSource = 1'b0;
        convData = 10'h000;
        {timerTrig, compareMatchB5, compareMatchA, overflowB, periodMatchA} = 10'h000;
    end
    // one result pulse; qualifiers are scrambled after it so stale data never looks valid
    task automatic conv(input logic [2:0] ch, input logic src, input logic [9:0] d);
        @(posedge clk);
        convDone <= 1'b1;
        convChannel <= ch;
        convSource <= src;
        convData <= d;
        @(posedge clk);
        convDone <= 1'b0;
        convChannel <= ~ch;
        convSource <= ~src;
        convData <= ~d;
    endtask
    task automatic tmr(input logic [9:0] v);
        @(posedge clk);
        {timerTrig, compareMatchB5, compareMatchA, overflowB, periodMatchA} <= v;
    endtask
endmodule

// ---- verif/test_adc_result_generation.sv ----
module test_adc_result_generation;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // stimulus, nets and scoreboard
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, convDone, convSource, periodMatchA, overflowB, compareMatchA, compareMatchB5;
    logic [2:0] convChannel;
    logic [9:0] convData, d0, d1;
    logic [5:0] timerTrig, trigRnd;
    logic [1:0] sourceTrigger, serviceRequest;
    logic resultWidthSelect, dataStoreEnable;
    logic [31:0] qRd[$];
    logic [1:0] qSr[$];
    int n_fail = 0;
    int n_tests = 0;
    int vals[5] = '{50, 100, 150, 200, 250};
    always #5 clk = ~clk;
    adcrg_top dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .convDone(convDone), .convChannel(convChannel),
        .convSource(convSource), .convData(convData), .periodMatchA(periodMatchA), .overflowB(overflowB),
        .compareMatchA(compareMatchA), .compareMatchB5(compareMatchB5), .timerTrig(timerTrig),
        .sourceTrigger(sourceTrigger), .serviceRequest(serviceRequest),
        .resultWidthSelect(resultWidthSelect), .dataStoreEnable(dataStoreEnable));
    adcrg_far_model far (.clk(clk), .convDone(convDone), .convChannel(convChannel), .convSource(convSource),
        .convData(convData), .periodMatchA(periodMatchA), .overflowB(overflowB), .compareMatchA(compareMatchA),
        .compareMatchB5(compareMatchB5), .timerTrig(timerTrig));
    // ==========================================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    // request held until waitrequest is seen low or 50 cycles pass, released at that edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (k == 50) n_fail++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        qRd.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    function automatic logic hit(input logic [2:0] c, input int v);
        int ar;
        ar = (v < 100) ? 1 : (v > 200) ? 3 : 2;
        case (c)
            3'h0: return 1'b0;
            3'h4: return 1'b1;
            3'h1, 3'h2, 3'h3: return ar != c;
            default: return ar == c - 4;
        endcase
    endfunction
    task automatic finish_test;
        if (qRd.size() != 0 || qSr.size() != 0) n_fail++;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ==========================================================
    // monitors: negedge sampling keeps them clear of edge races
    always @(negedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            chk("readdata", avs_readdata, qRd.size() ? qRd.pop_front() : 32'hx);
        if (serviceRequest !== 2'b00)
            chk("serviceRequest", serviceRequest, qSr.size() ? qSr.pop_front() : 2'bx);
    end
    // a hung main sequence ends the run here; a stuck handshake gives up in bus after 50 cycles
    initial begin
        #200000;
        n_fail++;
        finish_test;
    end
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(49849));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(adcrg_pkg::OFS_MISC, 32'h0);
        rd(adcrg_pkg::OFS_GLOB, 32'h0);
        bus(1'b1, adcrg_pkg::OFS_MISC, 32'hff);
        rd(adcrg_pkg::OFS_MISC, 32'hc1);
        chk("dataStoreEnable", dataStoreEnable, 1'b1);
        bus(1'b1, 8'hfc, 32'hffffffff);
        rd(8'hfc, 32'h0);
        $display("registers done");
        // filter pair: only the second store raises the event on line one
        bus(1'b1, adcrg_pkg::OFS_RESCTL, 32'h11);
        bus(1'b1, adcrg_pkg::OFS_EVPTR, 32'h10);
        d0 = 10'($urandom);
        d1 = 10'($urandom);
        far.conv(3'h0, 1'b0, d0);
        rd(adcrg_pkg::OFS_VALID, 32'h0);
        qSr.push_back(2'b10);
        far.conv(3'h0, 1'b0, d1);
        rd(8'h50, 32'({1'b0, d0} + {1'b0, d1}));
        rd(8'h40, 32'(10'(d0 + d1)));
        rd(adcrg_pkg::OFS_VALID, 32'h1);
        bus(1'b1, adcrg_pkg::OFS_VALID, 32'h1);
        rd(adcrg_pkg::OFS_VALID, 32'h0);
        far.conv(3'h0, 1'b0, d1);
        rd(8'h50, 32'(d1));
        $display("filter done");
        // every condition code against areas, boundaries themselves included
        bus(1'b1, adcrg_pkg::OFS_BOUND, 32'h00c80064);
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, 8'h24, 32'h10 | c);
            foreach (vals[i]) begin
                if (hit(3'(c), vals[i])) qSr.push_back(2'b01);
                far.conv(3'h1, 1'b1, 10'(vals[i]));
            end
        end
        rd(8'h44, 32'd250);
        $display("limits done");
        // source event on line zero and channel interrupt on line one together
        bus(1'b1, adcrg_pkg::OFS_RESCTL, 32'h111);
        bus(1'b1, adcrg_pkg::OFS_CHPTR, 32'h04);
        bus(1'b1, 8'h28, 32'h24);
        repeat (4) begin
            d0 = 10'($urandom);
            qSr.push_back(2'b11);
            far.conv(3'h2, 1'b0, d0);
            rd(8'h58, 32'(d0));
            rd(8'h48, 32'(d0));
        end
        bus(1'b1, adcrg_pkg::OFS_GLOB, 32'h40);
        chk("resultWidthSelect", resultWidthSelect, 1'b1);
        qSr.push_back(2'b11);
        far.conv(3'h2, 1'b0, 10'h3a5);
        rd(8'h48, 32'ha5);
        bus(1'b1, adcrg_pkg::OFS_GLOB, 32'h0);
        $display("routing done");
        // bypassed source zero on overflow, synchronised source one on input three
        bus(1'b1, adcrg_pkg::OFS_TRIG, 32'h38);
        bus(1'b1, adcrg_pkg::OFS_MISC, 32'h80);
        far.tmr(10'h022);
        repeat (2) @(negedge clk);
        chk("sourceTrigger", sourceTrigger, 2'b01);
        repeat (2) @(negedge clk);
        chk("sourceTrigger", sourceTrigger, 2'b11);
        far.tmr(10'h021);
        repeat (4) @(negedge clk);
        chk("sourceTrigger", sourceTrigger, 2'b10);
        @(posedge clk);
        bus(1'b1, adcrg_pkg::OFS_MISC, 32'h0);
        repeat (2) @(negedge clk);
        chk("sourceTrigger", sourceTrigger, 2'b11);
        far.tmr(10'h020);
        repeat (2) @(negedge clk);
        chk("sourceTrigger", sourceTrigger, 2'b10);
        // source zero bypassed on input one, source one synchronised on input seven
        @(posedge clk);
        bus(1'b1, adcrg_pkg::OFS_TRIG, 32'h79);
        bus(1'b1, adcrg_pkg::OFS_MISC, 32'h40);
        trigRnd = 6'($urandom);
        far.tmr({trigRnd, 4'h4});
        repeat (4) @(negedge clk);
        chk("sourceTrigger", sourceTrigger, {trigRnd[5], 1'b0});
        far.tmr({trigRnd, 4'h8});
        repeat (4) @(negedge clk);
        chk("sourceTrigger", sourceTrigger, {trigRnd[5], 1'b1});
        @(posedge clk);
        bus(1'b1, adcrg_pkg::OFS_MISC, 32'h0);
        repeat (2) @(negedge clk);
        chk("sourceTrigger", sourceTrigger, {trigRnd[5], 1'b0});
        $display("triggers done");
        finish_test;
    end
endmodule
